// [rtl/sbs_bank_ctrl.sv]
// Per-bank state tracking and command legality for a four-bank SDRAM core.
// Assumes commands are sampled on clk_sys rising edges, synchronous to it.
`timescale 1ns/100ps
`include "sbs_consts.svh"
module sbs_bank_ctrl
    import sbs_pkg::*;
#(
    parameter logic [`SBS_CNT_W-1:0] PRECHARGE_PERIOD = `SBS_T_RP_CLK,
    parameter logic [`SBS_CNT_W-1:0] ACTIVATE_TO_COLUMN_DELAY = `SBS_T_RCD_CLK,
    parameter logic [`SBS_CNT_W-1:0] WRITE_RECOVERY_PERIOD = `SBS_T_DPL_CLK,
    parameter logic [`SBS_CNT_W-1:0] ROW_CYCLE_TIME = `SBS_T_RC_CLK,
    parameter logic [`SBS_CNT_W-1:0] BURST_LENGTH = 8'h04
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [`SBS_BA_W-1:0] bank_addr,
    input wire logic [`SBS_ADDR_W-1:0] addr,
    output logic [`SBS_NUM_BANKS*4-1:0] bank_state_q,
    output logic illegal_cmd_q,
    output logic power_down_q,
    output logic self_refresh_q,
    output logic input_buf_en_q
);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic cke_prev_q;
    logic cmd_live;
    logic ap_bit;
    sbs_cmd_type cmd;
    logic [`SBS_NUM_BANKS-1:0] bank_idle;
    logic all_idle;
    logic [`SBS_NUM_BANKS-1:0] bank_illegal;
    logic low_power;

    assign ap_bit = addr[`SBS_AP_BIT];
    assign low_power = power_down_q | self_refresh_q;
    // Commands act only with clock enable high on both edges.
    assign cmd_live = cke_prev_q & cke & ~low_power;
    assign all_idle = &bank_idle;

    always_comb begin
        if (cs_n) begin
            cmd = SBS_CMD_DESELECT;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'b111: cmd = SBS_CMD_NOP;
                3'b110: cmd = SBS_CMD_BURST_STOP;
                3'b101: cmd = SBS_CMD_READ;
                3'b100: cmd = SBS_CMD_WRITE;
                3'b011: cmd = SBS_CMD_ROW_OPEN;
                3'b010: cmd = SBS_CMD_PRECHARGE;
                3'b001: cmd = SBS_CMD_REFRESH;
                default: cmd = SBS_CMD_MODE_SET;
            endcase
        end
    end

    // Reset clears the history, so no command acts on the first edge after release.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cke_prev_q <= 1'b0;
        end else begin
            cke_prev_q <= cke;
        end
    end

    // ------------------------------------------------------------
    // Per-bank state machines
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `SBS_NUM_BANKS; gi++) begin : g_bank
            sbs_bank_state_type st_q;
            sbs_bank_state_type st_d;
            logic [`SBS_CNT_W-1:0] cnt_q;
            logic [`SBS_CNT_W-1:0] cnt_d;
            logic sel;
            logic quiet;
            logic done;
            logic ill;

            // Legality uses the addressed bank, but refresh and mode access refuse commands to any bank; all-bank commands hit every bank.
            assign sel = (int'(bank_addr) == gi) ||
                         (cmd == SBS_CMD_PRECHARGE && ap_bit) ||
                         cmd == SBS_CMD_REFRESH || cmd == SBS_CMD_MODE_SET;
            assign quiet = cmd == SBS_CMD_DESELECT || cmd == SBS_CMD_NOP;
            // A spent counter rests at zero, so done holds until the state moves.
            assign done = cnt_q <= `SBS_CNT_ONE;
            assign bank_idle[gi] = st_q == SBS_IDLE;
            assign bank_illegal[gi] = ill;

            always_comb begin
                st_d = st_q;
                cnt_d = (cnt_q == `SBS_CNT_ZERO) ? cnt_q : cnt_q - `SBS_CNT_ONE;
                ill = 1'b0;
                if (cmd_live) begin
                    case (st_q)
                        SBS_IDLE: begin
                            if (sel && cmd == SBS_CMD_ROW_OPEN) begin
                                st_d = SBS_ACTIVATING;
                                cnt_d = ACTIVATE_TO_COLUMN_DELAY;
                            end else if (cmd == SBS_CMD_REFRESH) begin
                                st_d = SBS_REFRESH;
                                cnt_d = ROW_CYCLE_TIME;
                            end else if (cmd == SBS_CMD_MODE_SET) begin
                                st_d = SBS_MODE_ACCESS;
                                cnt_d = `SBS_MRS_CLK;
                            end else if (sel && (cmd == SBS_CMD_READ ||
                                                 cmd == SBS_CMD_WRITE)) begin
                                ill = 1'b1;
                            end
                        end
                        SBS_ACTIVE, SBS_READ, SBS_WRITE, SBS_WRECOVER: begin
                            if (sel && cmd == SBS_CMD_READ) begin
                                // Read after recovery relies on controller turnaround.
                                st_d = ap_bit ? SBS_READ_AP : SBS_READ;
                                cnt_d = BURST_LENGTH;
                            end else if (sel && cmd == SBS_CMD_WRITE) begin
                                st_d = ap_bit ? SBS_WRITE_AP : SBS_WRITE;
                                cnt_d = BURST_LENGTH;
                            end else if (sel && cmd == SBS_CMD_PRECHARGE &&
                                         st_q != SBS_WRECOVER) begin
                                st_d = SBS_PRECHARGING;
                                cnt_d = PRECHARGE_PERIOD;
                            end else if (st_q == SBS_WRECOVER && sel &&
                                         (cmd == SBS_CMD_PRECHARGE ||
                                          cmd == SBS_CMD_ROW_OPEN)) begin
                                ill = 1'b1;
                            end else if (sel && (cmd == SBS_CMD_ROW_OPEN ||
                                                 cmd == SBS_CMD_REFRESH ||
                                                 cmd == SBS_CMD_MODE_SET)) begin
                                ill = 1'b1;
                            end else if (sel && cmd == SBS_CMD_BURST_STOP &&
                                         st_q != SBS_WRECOVER) begin
                                st_d = SBS_ACTIVE;
                                cnt_d = `SBS_CNT_ZERO;
                            end else if (st_q == SBS_WRECOVER && done) begin
                                st_d = SBS_ACTIVE;
                            end else if (st_q == SBS_READ && done) begin
                                st_d = SBS_ACTIVE;
                            end else if (st_q == SBS_WRITE && done) begin
                                st_d = SBS_WRECOVER;
                                cnt_d = WRITE_RECOVERY_PERIOD;
                            end
                        end
                        SBS_READ_AP, SBS_WRITE_AP: begin
                            if (!quiet && sel) begin
                                ill = 1'b1;
                            end
                            // A refused command must not stretch the burst.
                            if (done && st_q == SBS_READ_AP) begin
                                st_d = SBS_PRECHARGING;
                                cnt_d = PRECHARGE_PERIOD;
                            end else if (done) begin
                                st_d = SBS_WRECOVER_AP;
                                cnt_d = WRITE_RECOVERY_PERIOD;
                            end
                        end
                        SBS_PRECHARGING: begin
                            if (sel && (cmd == SBS_CMD_READ || cmd == SBS_CMD_WRITE ||
                                        cmd == SBS_CMD_ROW_OPEN ||
                                        cmd == SBS_CMD_REFRESH ||
                                        cmd == SBS_CMD_MODE_SET)) begin
                                ill = 1'b1;
                            end
                            if (done) begin
                                st_d = SBS_IDLE;
                            end
                        end
                        SBS_ACTIVATING: begin
                            if (sel && !quiet && cmd != SBS_CMD_BURST_STOP) begin
                                ill = 1'b1;
                            end
                            if (done) begin
                                st_d = SBS_ACTIVE;
                            end
                        end
                        SBS_WRECOVER_AP: begin
                            if (sel && !quiet && cmd != SBS_CMD_BURST_STOP) begin
                                ill = 1'b1;
                            end
                            if (done) begin
                                // Burst stop here abandons the precharge.
                                st_d = (cmd == SBS_CMD_BURST_STOP && sel) ?
                                       SBS_ACTIVE : SBS_PRECHARGING;
                                cnt_d = PRECHARGE_PERIOD;
                            end
                        end
                        SBS_REFRESH: begin
                            if (!quiet && cmd != SBS_CMD_BURST_STOP) begin
                                ill = 1'b1;
                            end
                            if (done) begin
                                st_d = SBS_IDLE;
                            end
                        end
                        default: begin
                            if (!quiet) begin
                                ill = 1'b1;
                            end
                            if (done) begin
                                st_d = SBS_IDLE;
                            end
                        end
                    endcase
                end
            end

            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    st_q <= SBS_IDLE;
                    cnt_q <= `SBS_CNT_ZERO;
                end else begin
                    st_q <= st_d;
                    cnt_q <= cnt_d;
                end
            end

            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    // Same reset and next value as st_q, so the port is a flop of its own.
                    bank_state_q[gi*4 +: 4] <= SBS_IDLE;
                end else begin
                    bank_state_q[gi*4 +: 4] <= st_d;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Illegal flag and low-power modes
    // ------------------------------------------------------------
    // The flag pulses one cycle per refused command; ignored ones leave it low.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            illegal_cmd_q <= 1'b0;
        end else begin
            illegal_cmd_q <= |bank_illegal;
        end
    end

    // Entry needs enable high then low; any rise of enable exits.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            power_down_q <= 1'b0;
            self_refresh_q <= 1'b0;
        end else if (low_power) begin
            if (cke) begin
                power_down_q <= 1'b0;
                self_refresh_q <= 1'b0;
            end
        end else if (cke_prev_q && !cke && all_idle) begin
            if (cmd == SBS_CMD_REFRESH) begin
                self_refresh_q <= 1'b1;
            end else if (cmd == SBS_CMD_DESELECT || cmd == SBS_CMD_NOP) begin
                power_down_q <= 1'b1;
            end
        end
    end

    // Buffers other than clock enable are off in either low-power mode.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            input_buf_en_q <= 1'b1;
        end else if (low_power) begin
            input_buf_en_q <= cke;
        end else begin
            input_buf_en_q <= !(cke_prev_q && !cke && all_idle &&
                                (cmd == SBS_CMD_REFRESH || cmd == SBS_CMD_DESELECT ||
                                 cmd == SBS_CMD_NOP));
        end
    end

endmodule : sbs_bank_ctrl

// [rtl/sbs_consts.svh]
// Shared constants for the bank state and command legality block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH
`define SBS_NUM_BANKS 4
`define SBS_BA_W 2
`define SBS_CNT_W 8
`define SBS_AP_BIT 10
`define SBS_ADDR_W 13
`define SBS_T_RP_CLK 8'h03
`define SBS_T_RCD_CLK 8'h03
`define SBS_T_DPL_CLK 8'h02
`define SBS_T_RC_CLK 8'h09
`define SBS_MRS_CLK 8'h02
`define SBS_CNT_ZERO 8'h00
`define SBS_CNT_ONE 8'h01
`endif

// [rtl/sbs_pkg.sv]
// Types for the bank state and command legality block.
// Assumes the constants header sits in the include path.
`include "sbs_consts.svh"
package sbs_pkg;
    typedef enum logic [3:0] {
        SBS_IDLE = 4'b0000,
        SBS_ACTIVE = 4'b0001,
        SBS_READ = 4'b0010,
        SBS_WRITE = 4'b0011,
        SBS_READ_AP = 4'b0100,
        SBS_WRITE_AP = 4'b0101,
        SBS_PRECHARGING = 4'b0110,
        SBS_ACTIVATING = 4'b0111,
        SBS_WRECOVER = 4'b1000,
        SBS_WRECOVER_AP = 4'b1001,
        SBS_REFRESH = 4'b1010,
        SBS_MODE_ACCESS = 4'b1011
    } sbs_bank_state_type;
    typedef enum logic [3:0] {
        SBS_CMD_DESELECT = 4'h0,
        SBS_CMD_NOP = 4'h1,
        SBS_CMD_BURST_STOP = 4'h2,
        SBS_CMD_READ = 4'h3,
        SBS_CMD_WRITE = 4'h4,
        SBS_CMD_ROW_OPEN = 4'h5,
        SBS_CMD_PRECHARGE = 4'h6,
        SBS_CMD_REFRESH = 4'h7,
        SBS_CMD_MODE_SET = 4'h8
    } sbs_cmd_type;
endpackage : sbs_pkg

// [testbench/sbs_bank_ctrl_props.sv]
// Checker for the bank state and command legality block, bound to its ports.
// Assumes the default timing parameters; the sequences count bank 0 only.
`timescale 1ns/100ps
`include "sbs_consts.svh"
module sbs_bank_ctrl_props
    import sbs_pkg::*;
#(
    parameter logic [`SBS_CNT_W-1:0] PRECHARGE_PERIOD = `SBS_T_RP_CLK,
    parameter logic [`SBS_CNT_W-1:0] ACTIVATE_TO_COLUMN_DELAY = `SBS_T_RCD_CLK,
    parameter logic [`SBS_CNT_W-1:0] WRITE_RECOVERY_PERIOD = `SBS_T_DPL_CLK,
    parameter logic [`SBS_CNT_W-1:0] ROW_CYCLE_TIME = `SBS_T_RC_CLK,
    parameter logic [`SBS_CNT_W-1:0] BURST_LENGTH = 8'h04
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [`SBS_BA_W-1:0] bank_addr,
    input wire logic [`SBS_ADDR_W-1:0] addr,
    input wire logic [`SBS_NUM_BANKS*4-1:0] bank_state_q,
    input wire logic illegal_cmd_q,
    input wire logic power_down_q,
    input wire logic self_refresh_q,
    input wire logic input_buf_en_q
);
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire logic [3:0] st0 = bank_state_q[3:0];
    wire logic [3:0] pins = {cs_n, ras_n, cas_n, we_n};
    wire logic awake = cke && !power_down_q && !self_refresh_q;
    AST_ACT_TO_ACTIVE: assert property (
        st0 == 4'h7 && $past(st0) != 4'h7 |->
        ##1 st0 == 4'h7 ##1 st0 == 4'h7 ##1 st0 == 4'h1)
        else $error("activating did not last three cycles");
    AST_PRE_TO_IDLE: assert property (
        st0 == 4'h6 && $past(st0) != 4'h6 |-> ##1 (st0 == 4'h6) [*2] ##1 st0 == 4'h0)
        else $error("precharging did not last three cycles");
    AST_REFRESH_TO_IDLE: assert property (
        st0 == 4'hA && $past(st0) != 4'hA |-> ##1 (st0 == 4'hA) [*8] ##1 st0 == 4'h0)
        else $error("refresh did not last nine cycles");
    AST_MODE_TO_IDLE: assert property (
        st0 == 4'hB && $past(st0) != 4'hB |-> ##1 st0 == 4'hB ##1 st0 == 4'h0)
        else $error("mode access did not last two cycles");
    AST_READ_AP_CHAIN: assert property (
        st0 == 4'h4 && $past(st0) != 4'h4 |-> ##1 (st0 == 4'h4) [*3] ##1 st0 == 4'h6)
        else $error("read with auto precharge did not precharge");
    // A burst stop to bank 0 on the last recovery edge leaves the row open.
    AST_WRITE_AP_CHAIN: assert property (
        st0 == 4'h5 && $past(st0) != 4'h5 |-> ##1 (st0 == 4'h5) [*3] ##1 st0 == 4'h9 ##1
        st0 == 4'h9 ##1
        st0 == (($past(pins) == 4'h6 && $past(bank_addr) == 2'h0) ? 4'h1 : 4'h6))
        else $error("write with auto precharge chain broken");
    AST_ILLEGAL_ACT: assert property (
        pins == 4'h3 && bank_addr == 2'h0 && st0 == 4'h7 && $past(st0) != 4'h7 &&
        awake && $past(cke) && !$past(sys_rst) |=> illegal_cmd_q && st0 == 4'h7)
        else $error("second activate was accepted");
    AST_PER_BANK: assert property (
        pins == 4'h3 && bank_addr == 2'h1 && bank_state_q[7:4] == 4'h0 && awake &&
        $past(cke) && !$past(sys_rst) |=> !illegal_cmd_q && bank_state_q[7:4] == 4'h7)
        else $error("activate of an idle bank refused");
    AST_POWER_DOWN: assert property (
        bank_state_q == 16'h0000 && $past(cke) && !cke && (cs_n || pins == 4'h7) &&
        !power_down_q && !self_refresh_q && !$past(sys_rst) |=>
        power_down_q && !input_buf_en_q)
        else $error("power-down not entered");
    AST_BUF_OFF: assert property (
        power_down_q || self_refresh_q |-> !input_buf_en_q)
        else $error("input buffers on in low power");
endmodule : sbs_bank_ctrl_props
bind sbs_bank_ctrl sbs_bank_ctrl_props #(
    .PRECHARGE_PERIOD(PRECHARGE_PERIOD),
    .ACTIVATE_TO_COLUMN_DELAY(ACTIVATE_TO_COLUMN_DELAY),
    .WRITE_RECOVERY_PERIOD(WRITE_RECOVERY_PERIOD),
    .ROW_CYCLE_TIME(ROW_CYCLE_TIME),
    .BURST_LENGTH(BURST_LENGTH)
) i_props (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cke(cke),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .bank_addr(bank_addr),
    .addr(addr),
    .bank_state_q(bank_state_q),
    .illegal_cmd_q(illegal_cmd_q),
    .power_down_q(power_down_q),
    .self_refresh_q(self_refresh_q),
    .input_buf_en_q(input_buf_en_q)
);

// [testbench/sbs_ctrl_model.sv]
// Controller-side model turning one command request into SDRAM command pins.
// Assumes the bench updates the request just after each rising clock edge.
`timescale 1ns/100ps
module sbs_ctrl_model
    import sbs_pkg::*;
(
    input wire logic cke_req,
    input wire sbs_cmd_type cmd,
    input wire logic auto_pc,
    input wire logic [12:0] row,
    input wire logic [2:0] noise,
    output logic cke,
    output logic [3:0] pins,
    output logic [12:0] addr
);
    // ---------------------------------------------------------------
    // Pin encoding
    // ---------------------------------------------------------------
    // The bench also sequences illegal controller traffic to busy banks.
    assign cke = cke_req;
    assign addr = {row[12:11], auto_pc, row[9:0]};
    // Deselected lines wander so a stale value is never mistaken for a command.
    always_comb begin
        case (cmd)
            SBS_CMD_NOP: pins = 4'h7;
            SBS_CMD_BURST_STOP: pins = 4'h6;
            SBS_CMD_READ: pins = 4'h5;
            SBS_CMD_WRITE: pins = 4'h4;
            SBS_CMD_ROW_OPEN: pins = 4'h3;
            SBS_CMD_PRECHARGE: pins = 4'h2;
            SBS_CMD_REFRESH: pins = 4'h1;
            SBS_CMD_MODE_SET: pins = 4'h0;
            default: pins = {1'b1, noise};
        endcase
    end
endmodule : sbs_ctrl_model

// [testbench/tb_sbs_bank_state_command_legality.sv]
// Self-checking bench for the bank state and command legality block.
// Assumes the design's default timing parameters and a 50 ns clock.
`timescale 1ns/100ps
module tb_sbs_bank_state_command_legality
    import sbs_pkg::*;
;
    // ---------------------------------------------------------------
    // Stimulus and checking
    // ---------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cke_r = 1'b1;
    sbs_cmd_type cmd_r = SBS_CMD_NOP;
    logic [1:0] bank_r = 2'h0;
    logic ap_r = 1'b0;
    logic [12:0] row_r = 13'h0000;
    logic [2:0] noise_r = 3'h0;
    wire logic cke;
    wire logic [3:0] pins;
    wire logic [12:0] addr;
    logic [15:0] bank_state_q;
    logic illegal_cmd_q, power_down_q, self_refresh_q, input_buf_en_q;
    int failures = 0;
    int samples_checked = 0;
    initial forever #25 clk_sys = ~clk_sys;
    sbs_ctrl_model i_model (.cke_req(cke_r), .cmd(cmd_r), .auto_pc(ap_r), .row(row_r),
        .noise(noise_r), .cke(cke), .pins(pins), .addr(addr));
    sbs_bank_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cke(cke), .cs_n(pins[3]),
        .ras_n(pins[2]), .cas_n(pins[1]), .we_n(pins[0]), .bank_addr(bank_r), .addr(addr),
        .bank_state_q(bank_state_q), .illegal_cmd_q(illegal_cmd_q),
        .power_down_q(power_down_q), .self_refresh_q(self_refresh_q),
        .input_buf_en_q(input_buf_en_q));
    function automatic logic [3:0] st(input int b);
        return 4'(bank_state_q >> (b * 4));
    endfunction : st
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    // Outputs are sampled at the falling edge, after the launching edge settled.
    task automatic cmd_cyc(input sbs_cmd_type c, input logic [1:0] b, input logic ap,
        input logic k);
        @(posedge clk_sys);
        cmd_r <= c;
        bank_r <= b;
        ap_r <= ap;
        cke_r <= k;
        row_r <= 13'($urandom);
        noise_r <= 3'($urandom);
        @(negedge clk_sys);
    endtask : cmd_cyc
    task automatic idle_cyc();
        cmd_cyc(($urandom % 2) ? SBS_CMD_NOP : SBS_CMD_DESELECT, 2'($urandom), 1'b0, 1'b1);
    endtask : idle_cyc
    task automatic walk(input int b, input logic [3:0] s1, input int n1, input logic [3:0] s2,
        input int n2, input logic [3:0] s3, input int n3);
        for (int i = 0; i < n1 + n2 + n3; i++) begin
            idle_cyc();
            check("bank_state", 16'(st(b)), 16'(i < n1 ? s1 : (i < n1 + n2 ? s2 : s3)));
        end
    endtask : walk
    initial begin
        repeat (2000) @(posedge clk_sys);
        failures++;
        final_report();
    end
    initial begin
        void'($urandom(48));
        @(negedge clk_sys);
        check("reset_state", bank_state_q, 16'h0000);
        check("reset_buf_en", 16'(input_buf_en_q), 16'h0001);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        idle_cyc();
        idle_cyc();
        cmd_cyc(SBS_CMD_ROW_OPEN, 2'h0, 1'b0, 1'b1);
        cmd_cyc(SBS_CMD_ROW_OPEN, 2'h0, 1'b0, 1'b1);
        check("activating", 16'(st(0)), 16'(SBS_ACTIVATING));
        cmd_cyc(SBS_CMD_ROW_OPEN, 2'h1, 1'b0, 1'b1);
        check("illegal_act", 16'(illegal_cmd_q), 16'h0001);
        idle_cyc();
        check("other_bank", 16'(st(1)), 16'(SBS_ACTIVATING));
        check("legal_act", 16'(illegal_cmd_q), 16'h0000);
        idle_cyc();
        check("active", 16'(st(0)), 16'(SBS_ACTIVE));
        walk(1, SBS_ACTIVATING, 1, SBS_ACTIVE, 1, SBS_ACTIVE, 0);
        $display("test activate done");
        cmd_cyc(SBS_CMD_READ, 2'h0, 1'b1, 1'b1);
        walk(0, SBS_READ_AP, 4, SBS_PRECHARGING, 3, SBS_IDLE, 1);
        cmd_cyc(SBS_CMD_ROW_OPEN, 2'h0, 1'b0, 1'b1);
        walk(0, SBS_ACTIVATING, 3, SBS_ACTIVE, 1, SBS_ACTIVE, 0);
        cmd_cyc(SBS_CMD_WRITE, 2'h0, 1'b1, 1'b1);
        walk(0, SBS_WRITE_AP, 4, SBS_WRECOVER_AP, 2, SBS_PRECHARGING, 3);
        cmd_cyc(SBS_CMD_ROW_OPEN, 2'h0, 1'b0, 1'b1);
        walk(0, SBS_ACTIVATING, 3, SBS_ACTIVE, 1, SBS_ACTIVE, 0);
        cmd_cyc(SBS_CMD_WRITE, 2'h0, 1'b0, 1'b1);
        walk(0, SBS_WRITE, 4, SBS_WRECOVER, 2, SBS_ACTIVE, 1);
        $display("test auto precharge done");
        cmd_cyc(SBS_CMD_PRECHARGE, 2'h0, 1'b0, 1'b1);
        cmd_cyc(SBS_CMD_READ, 2'h0, 1'b0, 1'b1);
        idle_cyc();
        check("illegal_read", 16'(illegal_cmd_q), 16'h0001);
        walk(0, SBS_PRECHARGING, 1, SBS_IDLE, 1, SBS_IDLE, 0);
        cmd_cyc(SBS_CMD_PRECHARGE, 2'h0, 1'b1, 1'b1);
        walk(1, SBS_PRECHARGING, 3, SBS_IDLE, 1, SBS_IDLE, 0);
        $display("test precharge done");
        cmd_cyc(SBS_CMD_REFRESH, 2'h0, 1'b0, 1'b1);
        walk(0, SBS_REFRESH, 9, SBS_IDLE, 1, SBS_IDLE, 0);
        cmd_cyc(SBS_CMD_MODE_SET, 2'h0, 1'b0, 1'b1);
        walk(0, SBS_MODE_ACCESS, 2, SBS_IDLE, 1, SBS_IDLE, 0);
        $display("test refresh and mode set done");
        cmd_cyc(SBS_CMD_ROW_OPEN, 2'h0, 1'b0, 1'b1);
        walk(0, SBS_ACTIVATING, 3, SBS_ACTIVE, 1, SBS_ACTIVE, 0);
        cmd_cyc(SBS_CMD_WRITE, 2'h0, 1'b1, 1'b1);
        walk(0, SBS_WRITE_AP, 4, SBS_WRECOVER_AP, 1, SBS_WRECOVER_AP, 0);
        // Burst stop lands on the last recovery edge and keeps the row open.
        cmd_cyc(SBS_CMD_BURST_STOP, 2'h0, 1'b0, 1'b1);
        idle_cyc();
        check("stop_recover", 16'({illegal_cmd_q, st(0)}), 16'(SBS_ACTIVE));
        cmd_cyc(SBS_CMD_PRECHARGE, 2'h0, 1'b0, 1'b1);
        walk(0, SBS_PRECHARGING, 3, SBS_IDLE, 1, SBS_IDLE, 0);
        $display("test burst stop done");
        cmd_cyc(SBS_CMD_NOP, 2'h0, 1'b0, 1'b0);
        cmd_cyc(SBS_CMD_NOP, 2'h0, 1'b0, 1'b0);
        check("power_down", 16'({power_down_q, input_buf_en_q}), 16'h0002);
        idle_cyc();
        idle_cyc();
        idle_cyc();
        check("power_up", 16'({power_down_q, input_buf_en_q}), 16'h0001);
        cmd_cyc(SBS_CMD_REFRESH, 2'h0, 1'b0, 1'b0);
        cmd_cyc(SBS_CMD_NOP, 2'h0, 1'b0, 1'b0);
        check("self_refresh", 16'({self_refresh_q, input_buf_en_q}), 16'h0002);
        $display("test low power done");
        final_report();
    end
endmodule : tb_sbs_bank_state_command_legality
